/* File: include/psc_pkg.sv */
// Package of constants for the panel run/stop/step control.
package psc_pkg;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS    = 100;
  localparam int SLOW_PACE_MS     = 786;
  localparam int NORMAL_PACE_MS   = 3;
  // Slow tick period in clock cycles, longest time rounds down.
  localparam int SLOW_PACE_CYCLES = (SLOW_PACE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int DIV_W            = 24;
  localparam int PANEL_DIV_W      = 4;
  localparam int PANEL_DIV_CYCLES = 16;

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [DIV_W-1:0]       DIV_RST       = 24'h000000;
  localparam logic [PANEL_DIV_W-1:0] PANEL_DIV_RST = 4'h0;

  typedef enum logic [1:0] {
    PSC_RUN  = 2'b00,
    PSC_STOP = 2'b01,
    PSC_STEP = 2'b11
  } psc_mode_t;

endpackage : psc_pkg

/* File: rtl/psc_panel_ctrl.sv */
// Front-panel run, stop, single-step and slow-step control.
// How it works
// - One panel ready output: low makes the processor wait, high lets it run.
// - Operator stop clears the run condition, dropping panel ready.
// - Stop input passes two latch stages, each on a panel tick.
// - Stop flop is loaded only on sync, strobe and fetch status together.
// - That coincidence only occurs in machine cycle one.
// - Once set, the stop flop holds itself until a run command.
// - While stopped, the other panel switches are enabled.
// - A step request sets the step flop, raising panel ready.
// - Next fetch coincidence clears the step flop, back to wait.
// - Outside slow mode, every further step needs a new step press.
// - Pulling either strap drops fetch status from the clear: step per machine cycle.
// - Slow mode gates a 24-bit divider tick into the step set path.
// - Slow pace is about 786 ms per instruction cycle.
// - After a slow step another starts while slow is still selected.
`timescale 1ns/1ns
module psc_panel_ctrl
  import psc_pkg::*;
#(
  parameter int SLOW_CYCLES = SLOW_PACE_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic stop_req,
  input  wire logic run_req,
  input  wire logic step_req,
  input  wire logic slow_sel,
  input  wire logic fetch_qualify_strap_a,
  input  wire logic fetch_qualify_strap_b,
  input  wire logic cycle_sync,
  input  wire logic status_latch_strobe,
  input  wire logic fetch_status_bit,
  output logic      panel_ready_out,
  output logic      switches_enable,
  output logic      panel_sync_tick,
  output logic      slow_pace_tick
);

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  // Every pin passes two flops; the first stage is read by nothing else.
  // The straps are combined only after the second stage, so no gate sees a raw pin.
  logic [8:0] pin_meta_reg;
  logic [8:0] pin_sync_reg;
  wire  [8:0] pin_raw = {stop_req, run_req, step_req, slow_sel, fetch_qualify_strap_a,
                         fetch_qualify_strap_b, cycle_sync, status_latch_strobe,
                         fetch_status_bit};

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_meta_reg <= 9'h000;
      pin_sync_reg <= 9'h000;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  wire stop_s   = pin_sync_reg[8];
  wire run_s    = pin_sync_reg[7];
  wire step_s   = pin_sync_reg[6];
  wire slow_s   = pin_sync_reg[5];
  // Both straps must be fitted for fetch status to qualify the step clear.
  wire strap_s  = pin_sync_reg[4] & pin_sync_reg[3];
  wire sync_s   = pin_sync_reg[2];
  wire strobe_s = pin_sync_reg[1];
  wire fetch_s  = pin_sync_reg[0];

  // ***************************************************************
  // Panel tick and slow divider
  // ***************************************************************
  logic [PANEL_DIV_W-1:0] panel_div_reg;
  logic [DIV_W-1:0]       slow_div_reg;
  logic                   panel_tick_reg;
  logic                   slow_tick_reg;

  wire panel_wrap = (panel_div_reg == PANEL_DIV_W'(PANEL_DIV_CYCLES - 1));
  wire slow_wrap  = (slow_div_reg == DIV_W'(SLOW_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      panel_div_reg  <= PANEL_DIV_RST;
      slow_div_reg   <= DIV_RST;
      panel_tick_reg <= 1'b0;
      slow_tick_reg  <= 1'b0;
    end else begin
      panel_div_reg  <= panel_wrap ? PANEL_DIV_RST : panel_div_reg + 1'b1;
      slow_div_reg   <= slow_wrap ? DIV_RST : slow_div_reg + 1'b1;
      panel_tick_reg <= panel_wrap;
      slow_tick_reg  <= slow_wrap;
    end
  end

  // ***************************************************************
  // Stop path and qualifying coincidence
  // ***************************************************************
  logic stop_sync_stage_one;
  logic stop_sync_stage_two;
  logic step_prev_reg;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stop_sync_stage_one <= 1'b0;
      stop_sync_stage_two <= 1'b0;
    end else if (panel_tick_reg) begin
      stop_sync_stage_one <= stop_s;
      stop_sync_stage_two <= stop_sync_stage_one;
    end
  end

  // Fetch status is only high in machine cycle one, so this marks an instruction start.
  wire fetch_start = sync_s & strobe_s & fetch_s;
  // Without the strap every machine cycle's sync clears the step flop.
  wire step_clear  = sync_s & strobe_s & (fetch_s | ~strap_s);
  wire step_pulse  = step_s & ~step_prev_reg;
  wire step_set    = step_pulse | (slow_s & slow_tick_reg);

  // ***************************************************************
  // Control state machine
  // ***************************************************************
  psc_mode_t mode_reg;
  psc_mode_t mode_next;

  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      PSC_RUN: begin
        if (stop_sync_stage_two && fetch_start) begin
          mode_next = PSC_STOP;
        end
      end
      PSC_STOP: begin
        if (run_s) begin
          mode_next = PSC_RUN;
        end else if (step_set) begin
          mode_next = PSC_STEP;
        end
      end
      PSC_STEP: begin
        if (step_clear) begin
          mode_next = PSC_STOP;
        end
      end
      default: mode_next = PSC_STOP;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_reg        <= PSC_RUN;
      step_prev_reg   <= 1'b0;
      panel_ready_out <= 1'b1;
      switches_enable <= 1'b0;
    end else begin
      mode_reg        <= mode_next;
      step_prev_reg   <= step_s;
      panel_ready_out <= (mode_next != PSC_STOP);
      switches_enable <= (mode_next == PSC_STOP);
    end
  end

  assign panel_sync_tick = panel_tick_reg;
  assign slow_pace_tick  = slow_tick_reg;

  // ***************************************************************
  // Checks
  // ***************************************************************
  // Each step of the control is named once here and reused by the properties below.
  sequence s_step_begin;
    mode_reg == PSC_STOP && !run_s && step_set;
  endsequence

  sequence s_stop_take;
    mode_reg == PSC_RUN && stop_sync_stage_two && fetch_start;
  endsequence

  sequence s_step_end;
    mode_reg == PSC_STEP && step_clear;
  endsequence

  sequence s_run_take;
    mode_reg == PSC_STOP && run_s;
  endsequence

  sequence s_slow_take;
    mode_reg == PSC_STOP && !run_s && slow_s && slow_tick_reg;
  endsequence

  sequence s_idle_stop;
    mode_reg == PSC_STOP && !run_s && !step_set;
  endsequence

  // Stop path: the request only bites at an instruction start.
  a_stop_gates_ready: assert property (@(posedge clk) disable iff (!rst_b)
    s_stop_take |=> !panel_ready_out)
    else $error("stop at fetch did not drop ready");

  a_stop_needs_fetch: assert property (@(posedge clk) disable iff (!rst_b)
    $past(mode_reg) == PSC_RUN && mode_reg == PSC_STOP |-> $past(fetch_start))
    else $error("stop taken outside fetch");

  a_no_stop_offfetch: assert property (@(posedge clk) disable iff (!rst_b)
    mode_reg == PSC_RUN && !fetch_start |=> mode_reg == PSC_RUN)
    else $error("run left outside machine cycle one");

  a_stop_holds_set: assert property (@(posedge clk) disable iff (!rst_b)
    s_idle_stop |=> mode_reg == PSC_STOP)
    else $error("stop flop released itself");

  a_mode_legal: assert property (@(posedge clk) disable iff (!rst_b)
    mode_reg inside {PSC_RUN, PSC_STOP, PSC_STEP})
    else $error("control state left its legal codes");

  // Two-stage stop latch moves only on panel ticks.
  a_stage_two_tick: assert property (@(posedge clk) disable iff (!rst_b)
    !panel_tick_reg |=> $stable(stop_sync_stage_two))
    else $error("stop stage moved off tick");

  a_stage_one_tick: assert property (@(posedge clk) disable iff (!rst_b)
    !panel_tick_reg |=> $stable(stop_sync_stage_one))
    else $error("first stop stage moved off tick");

  a_stage_one_loads: assert property (@(posedge clk) disable iff (!rst_b)
    panel_tick_reg |=> stop_sync_stage_one == $past(stop_s))
    else $error("first stop stage missed its tick");

  a_stage_two_follow: assert property (@(posedge clk) disable iff (!rst_b)
    panel_tick_reg |=> stop_sync_stage_two == $past(stop_sync_stage_one))
    else $error("second stop stage missed its tick");

  a_panel_tick_one: assert property (@(posedge clk) disable iff (!rst_b)
    panel_tick_reg |=> !panel_tick_reg)
    else $error("panel tick longer than one cycle");

  // Step path: one press, one instruction or machine cycle.
  a_step_raises_rdy: assert property (@(posedge clk) disable iff (!rst_b)
    s_step_begin |=> panel_ready_out && mode_reg == PSC_STEP)
    else $error("step did not raise ready");

  a_step_holds: assert property (@(posedge clk) disable iff (!rst_b)
    mode_reg == PSC_STEP && !step_clear |=> mode_reg == PSC_STEP)
    else $error("step ended without its clear");

  a_step_clears_rdy: assert property (@(posedge clk) disable iff (!rst_b)
    s_step_end |=> !panel_ready_out)
    else $error("fetch did not end step");

  a_no_auto_repeat: assert property (@(posedge clk) disable iff (!rst_b)
    s_idle_stop |=> !panel_ready_out)
    else $error("step repeated without a press");

  a_strap_off_clear: assert property (@(posedge clk) disable iff (!rst_b)
    mode_reg == PSC_STEP && sync_s && strobe_s && !strap_s |=> mode_reg == PSC_STOP)
    else $error("strap off did not end step per cycle");

  a_strap_on_waits: assert property (@(posedge clk) disable iff (!rst_b)
    mode_reg == PSC_STEP && strap_s && !fetch_s |=> panel_ready_out)
    else $error("strap on ended step outside fetch");

  a_one_step_press: assert property (@(posedge clk) disable iff (!rst_b)
    step_pulse |=> !step_pulse)
    else $error("step press gave two pulses");

  // Slow path: the divider tick stands in for the step press.
  a_slow_tick_one: assert property (@(posedge clk) disable iff (!rst_b)
    slow_tick_reg |=> !slow_tick_reg)
    else $error("slow tick longer than one cycle");

  a_slow_wrap_tick: assert property (@(posedge clk) disable iff (!rst_b)
    slow_wrap |=> slow_tick_reg)
    else $error("slow divider wrap gave no tick");

  a_slow_restep: assert property (@(posedge clk) disable iff (!rst_b)
    s_slow_take |=> mode_reg == PSC_STEP)
    else $error("slow tick did not start step");

  a_slow_off_stays: assert property (@(posedge clk) disable iff (!rst_b)
    mode_reg == PSC_STOP && !run_s && !slow_s && !step_pulse |=> mode_reg == PSC_STOP)
    else $error("halt left with slow deselected");

  // Run path and the outputs that follow the control state.
  a_run_restores: assert property (@(posedge clk) disable iff (!rst_b)
    s_run_take |=> panel_ready_out && !switches_enable)
    else $error("run did not restore ready");

  a_run_priority: assert property (@(posedge clk) disable iff (!rst_b)
    mode_reg == PSC_STOP && run_s && step_set |=> mode_reg == PSC_RUN)
    else $error("step beat run while stopped");

  a_ready_tracks: assert property (@(posedge clk) disable iff (!rst_b)
    panel_ready_out == (mode_reg != PSC_STOP))
    else $error("panel ready not tied to state");

  a_switch_enable: assert property (@(posedge clk) disable iff (!rst_b)
    switches_enable == (mode_reg == PSC_STOP))
    else $error("switch enable not tied to stop");

endmodule : psc_panel_ctrl

/* File: tb/psc_bus_model.sv */
// Behavioural processor bus model that answers the panel ready line.
`timescale 1ns/1ns
module psc_bus_model (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic panel_ready_out,
  output logic      cycle_sync,
  output logic      status_latch_strobe,
  output logic      fetch_status_bit,
  output int        m1_count,
  output int        mc_count
);
  int t;
  int mc;
  // Eight clocks a machine cycle, three machine cycles an instruction.
  always @(negedge clk) begin
    if (!rst_b) begin
      t = 0; mc = 0; m1_count = 0; mc_count = 0;
      cycle_sync = 1'b0; status_latch_strobe = 1'b0; fetch_status_bit = 1'b1;
    end else if (panel_ready_out) begin
      t = (t + 1) % 8;
      cycle_sync = (t == 0);
      status_latch_strobe = (t == 0);
      if (t == 0) begin
        mc = (mc + 1) % 3;
        mc_count++;
        if (mc == 0) m1_count++;
      end
      fetch_status_bit = (mc == 0);
    end else begin
      cycle_sync = 1'b0;
      status_latch_strobe = 1'b0;
    end
  end
endmodule : psc_bus_model

/* File: tb/test_psc_panel_ctrl.sv */
// Self-checking testbench for the panel run/stop/step control.
`timescale 1ns/1ns
module test_psc_panel_ctrl;
  logic clk = 0, rst_b = 0, stop_req = 0, run_req = 0, step_req = 0, slow_sel = 0;
  logic sa = 1, sb = 1, cs, ss, fs, rdy, sw_en, ptick, stick;
  int   m1, mcn, n_fail = 0, check_count = 0, a, b, g;
  always #50 clk = ~clk;
  psc_panel_ctrl #(.SLOW_CYCLES(200)) u_dut (.clk(clk), .rst_b(rst_b), .stop_req(stop_req),
    .run_req(run_req), .step_req(step_req), .slow_sel(slow_sel), .fetch_qualify_strap_a(sa),
    .fetch_qualify_strap_b(sb), .cycle_sync(cs), .status_latch_strobe(ss),
    .fetch_status_bit(fs), .panel_ready_out(rdy), .switches_enable(sw_en),
    .panel_sync_tick(ptick), .slow_pace_tick(stick));
  psc_bus_model u_bus (.clk(clk), .rst_b(rst_b), .panel_ready_out(rdy), .cycle_sync(cs),
    .status_latch_strobe(ss), .fetch_status_bit(fs), .m1_count(m1), .mc_count(mcn));
  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_rdy(input logic v, input int lim);
    for (int i = 0; i < lim && rdy !== v; i++) @(negedge clk);
    chk(rdy, v);
  endtask : wait_rdy
  // Gap in clocks between two pulses of the chosen tick.
  task automatic gap(input bit slow, output int n);
    n = 0;
    while ((slow ? stick : ptick) !== 1'b1) @(negedge clk);
    do begin @(negedge clk); n++; end while ((slow ? stick : ptick) !== 1'b1 && n < 999);
  endtask : gap
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_stop;
    stop_req = 1;
    wait_rdy(0, 300);
    chk(fs, 1'b1);
    chk(sw_en, 1'b1);
    stop_req = 0;
    a = m1;
    repeat (100) @(negedge clk);
    chk(rdy, 1'b0);
    chk(m1, a);
    $display("stop test done");
  endtask : t_stop
  // Step switch held down throughout; only one instruction may run, or one machine cycle with the strap off.
  task automatic t_step(input logic strap);
    sa = strap; a = m1; b = mcn; step_req = 1;
    wait_rdy(1, 10);
    wait_rdy(0, 100);
    repeat (100) @(negedge clk);
    chk(rdy, 1'b0);
    chk(m1 - a, strap ? 1 : 0);
    chk(mcn - b, strap ? 3 : 1);
    step_req = 0; sa = 1;
    repeat (5) @(negedge clk);
    $display("step test done, strap %0d", strap);
  endtask : t_step
  task automatic t_slow;
    gap(1, g);
    chk(g, 200);
    gap(0, g);
    chk(g, 16);
    slow_sel = 1; a = m1;
    repeat (1000) @(negedge clk);
    chk(m1 - a >= 4 && m1 - a <= 5, 1'b1);
    slow_sel = 0;
    wait_rdy(0, 100);
    a = m1;
    repeat (300) @(negedge clk);
    chk(m1, a);
    $display("slow test done");
  endtask : t_slow
  task automatic t_run;
    run_req = 1;
    wait_rdy(1, 10);
    run_req = 0;
    chk(sw_en, 1'b0);
    a = m1;
    repeat (100) @(negedge clk);
    chk(m1 > a, 1'b1);
    $display("run test done");
  endtask : t_run
  initial begin
    repeat (20) @(negedge clk);
    rst_b = 1;
    chk(rdy, 1'b1);
    chk(sw_en, 1'b0);
    $display("reset test done");
    t_stop;
    t_step(1);
    t_step(0);
    t_slow;
    t_run;
    t_stop;
    tally_and_finish;
  end
  // The tests need about 3000 clocks; the watchdog allows ten times that.
  initial begin
    #3000000;
    n_fail++;
    tally_and_finish;
  end
endmodule : test_psc_panel_ctrl
